// File: stack_push_exec.sv
// execution logic for system and user stack push instructions
// Function
// - system push: decrement stack pointer, then write source at new pointer.
// - stack pointer is 16 bits and wraps; zero decrements to all ones.
// - user push down: decrement pointer register, write source at new pointer.
// - user push down is opcode 82, three bytes, eight cycles.
// - no push instruction changes any condition flag.
module stack_push_exec
   import stack_push_pkg::*;
(
   input wire logic i_ref_clk,          // core clock
   input wire logic i_rst,              // async reset, active high
   input wire logic i_start,            // front end offers an instruction
   input wire instr_t i_instr,          // opcode and operand bytes
   output logic o_ready,                // instruction may be offered
   output logic o_busy,                 // instruction executing
   output logic o_done,                 // last cycle of instruction
   output logic o_bad_op,               // offered opcode not handled
   output logic [1:0] o_len,            // length of accepted instruction
   output rf_rd_t o_rf_rd,              // register file read request
   input wire logic [7:0] i_rf_rd_data, // read data, one cycle later
   output rf_wr_t o_rf_wr,              // register file write
   output mem_wr_t o_mem_wr,            // stack memory write
   input wire logic i_sp_hi_wr,         // load stack_pointer_high_byte
   input wire logic i_sp_lo_wr,         // load stack_pointer_low_byte
   input wire logic [7:0] i_sp_wr_data, // data for pointer byte loads
   output logic [15:0] o_sp,            // system_stack_pointer
   output logic o_flags_we              // condition flag write enable
);

   exec_state_t cur;
   exec_state_t next_cur;
   op_kind_t dec_kind;
   logic dec_valid;
   logic [1:0] dec_len;

   // kind that keeps its stack in the register file
   function automatic logic is_user_push(input op_kind_t k);
      is_user_push = (k == KIND_PUSH_USER_DOWN);
   endfunction

   // counter value of the last of the eight cycles
   function automatic logic is_last(input logic [3:0] c);
      is_last = (c == `PUSH_CYCLES - 4'h1);
   endfunction

   // opcode decoder
   stack_push_decode u_decode (
      .i_opcode(i_instr.opcode),
      .o_kind(dec_kind),
      .o_valid(dec_valid),
      .o_len(dec_len)
   );

   // handshake and registered outputs
   assign o_ready = (cur.phase == ST_IDLE);
   assign o_busy = (cur.phase != ST_IDLE);
   assign o_done = cur.done;
   assign o_bad_op = cur.bad_op;
   assign o_len = cur.len;
   assign o_rf_rd = cur.rd;
   assign o_rf_wr = cur.wr;
   assign o_mem_wr = cur.mem;
   assign o_sp = cur.sp;
   assign o_flags_we = 1'b0;

   // next state of the whole block
   always_comb begin
      next_cur = cur;
      next_cur.rd.en = 1'b0;
      next_cur.wr.en = 1'b0;
      next_cur.mem.en = 1'b0;
      next_cur.done = 1'b0;
      next_cur.bad_op = 1'b0;
      if (cur.phase != ST_IDLE) begin
         next_cur.cnt = cur.cnt + 4'h1;
      end
      // pointer byte loads by other instructions
      if (i_sp_hi_wr) begin
         next_cur.sp[15:8] = i_sp_wr_data;
      end
      if (i_sp_lo_wr) begin
         next_cur.sp[7:0] = i_sp_wr_data;
      end
      case (cur.phase)
         ST_IDLE: begin
            if (i_start && dec_valid) begin
               next_cur.phase = ST_FETCH;
               next_cur.kind = dec_kind;
               next_cur.len = dec_len;
               next_cur.cnt = 4'h1;
               next_cur.rd.en = 1'b1;
               if (is_user_push(dec_kind)) begin
                  // dst byte names the pointer register
                  next_cur.dst = i_instr.byte1;
                  next_cur.src = i_instr.byte2;
                  next_cur.rd.addr = i_instr.byte1;
               end else begin
                  next_cur.src = i_instr.byte1;
                  next_cur.dst = 8'h00;
                  next_cur.rd.addr = i_instr.byte1;
               end
            end else if (i_start) begin
               next_cur.bad_op = 1'b1;
            end
         end
         ST_FETCH: begin
            // first read returns in the second busy cycle
            if (cur.cnt == 4'h2) begin
               case (cur.kind)
                  KIND_PUSH_REG: begin
                     next_cur.data = i_rf_rd_data;
                     next_cur.phase = ST_STORE;
                  end
                  KIND_PUSH_IND: begin
                     // source register holds the operand address
                     next_cur.rd.en = 1'b1;
                     next_cur.rd.addr = i_rf_rd_data;
                     next_cur.phase = ST_INDIRECT;
                  end
                  KIND_PUSH_USER_DOWN: begin
                     next_cur.ptr = dec8(i_rf_rd_data);
                     next_cur.rd.en = 1'b1;
                     next_cur.rd.addr = cur.src;
                     next_cur.phase = ST_INDIRECT;
                  end
                  default: begin
                     next_cur.phase = ST_SETTLE;
                  end
               endcase
            end
         end
         ST_INDIRECT: begin
            // second read returns two cycles after the first
            if (cur.cnt == 4'h4) begin
               next_cur.data = i_rf_rd_data;
               next_cur.phase = ST_STORE;
               if (is_user_push(cur.kind)) begin
                  // pointer register takes decremented value first
                  next_cur.wr.en = 1'b1;
                  next_cur.wr.addr = cur.dst;
                  next_cur.wr.data = cur.ptr;
               end
            end
         end
         ST_STORE: begin
            next_cur.phase = ST_SETTLE;
            if (is_user_push(cur.kind)) begin
               // source byte lands at the decremented pointer
               next_cur.wr.en = 1'b1;
               next_cur.wr.addr = cur.ptr;
               next_cur.wr.data = cur.data;
            end else begin
               // pre-decrement, then store at the new top
               next_cur.sp = dec16(cur.sp);
               next_cur.mem.en = 1'b1;
               next_cur.mem.addr = dec16(cur.sp);
               next_cur.mem.data = cur.data;
            end
         end
         ST_SETTLE: begin
            // pad to the fixed instruction length
            if (is_last(cur.cnt)) begin
               next_cur.phase = ST_IDLE;
               next_cur.cnt = 4'h0;
            end
         end
         default: begin
            next_cur.phase = ST_IDLE;
         end
      endcase
      // done marks the last of the eight cycles
      if (next_cur.phase != ST_IDLE
            && is_last(next_cur.cnt)) begin
         next_cur.done = 1'b1;
      end
   end

   // state register
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         cur <= '0;
         cur.phase <= ST_IDLE;
         cur.kind <= KIND_NONE;
         cur.sp <= `SP_RESET;
      end else begin
         cur <= next_cur;
      end
   end
endmodule

// File: stack_push_consts.svh
// constants for the stack push execution block
`ifndef STACK_PUSH_CONSTS_SVH
`define STACK_PUSH_CONSTS_SVH

// opcodes of the handled instructions
`define OPC_PUSH_REG 8'h70
`define OPC_PUSH_IND 8'h71
`define OPC_PUSH_USER_DOWN 8'h82

// instruction lengths in bytes
`define LEN_PUSH 2'h2
`define LEN_PUSH_USER_DOWN 2'h3

// every handled instruction occupies this many clock cycles
`define PUSH_CYCLES 4'h8

// system stack pointer value after reset
`define SP_RESET 16'h0000

`endif

// File: stack_push_pkg.sv
// types shared by the stack push execution block
package stack_push_pkg;
   `include "stack_push_consts.svh"

   // instruction kinds recognised by the decoder
   typedef enum logic [1:0] {
      KIND_NONE,
      KIND_PUSH_REG,
      KIND_PUSH_IND,
      KIND_PUSH_USER_DOWN
   } op_kind_t;

   // execution phases
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FETCH,
      ST_INDIRECT,
      ST_STORE,
      ST_SETTLE
   } phase_t;

   // instruction as handed over by the front end
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] byte1;
      logic [7:0] byte2;
   } instr_t;

   // register file read request
   typedef struct packed {
      logic en;
      logic [7:0] addr;
   } rf_rd_t;

   // register file write request
   typedef struct packed {
      logic en;
      logic [7:0] addr;
      logic [7:0] data;
   } rf_wr_t;

   // data memory write request
   typedef struct packed {
      logic en;
      logic [15:0] addr;
      logic [7:0] data;
   } mem_wr_t;

   // whole state of the execution block
   typedef struct packed {
      phase_t phase;
      op_kind_t kind;
      logic [3:0] cnt;
      logic [7:0] src;
      logic [7:0] dst;
      logic [7:0] data;
      logic [7:0] ptr;
      logic [15:0] sp;
      logic [1:0] len;
      rf_rd_t rd;
      rf_wr_t wr;
      mem_wr_t mem;
      logic done;
      logic bad_op;
   } exec_state_t;

   // 8-bit pre-decrement, wraps at zero
   function automatic logic [7:0] dec8(input logic [7:0] v);
      dec8 = v - 8'h01;
   endfunction

   // 16-bit pre-decrement, wraps modulo 2^16
   function automatic logic [15:0] dec16(input logic [15:0] v);
      dec16 = v - 16'h0001;
   endfunction
endpackage

// File: stack_push_decode.sv
// opcode decoder for the stack push instructions
module stack_push_decode
   import stack_push_pkg::*;
(
   input wire logic [7:0] i_opcode, // first instruction byte
   output op_kind_t o_kind,         // recognised instruction kind
   output logic o_valid,            // opcode is handled here
   output logic [1:0] o_len         // instruction length in bytes
);

   // opcode to kind and length
   always_comb begin
      o_kind = KIND_NONE;
      o_valid = 1'b0;
      o_len = 2'h0;
      case (i_opcode)
         `OPC_PUSH_REG: begin
            o_kind = KIND_PUSH_REG;
            o_valid = 1'b1;
            o_len = `LEN_PUSH;
         end
         `OPC_PUSH_IND: begin
            o_kind = KIND_PUSH_IND;
            o_valid = 1'b1;
            o_len = `LEN_PUSH;
         end
         `OPC_PUSH_USER_DOWN: begin
            o_kind = KIND_PUSH_USER_DOWN;
            o_valid = 1'b1;
            o_len = `LEN_PUSH_USER_DOWN;
         end
         default: begin
            o_kind = KIND_NONE;
         end
      endcase
   end
endmodule

// File: stack_push_checker.sv
// port assertions for the stack push execution block
module stack_push_checker
   import stack_push_pkg::*;
(
   input wire logic i_ref_clk, // core clock
   input wire logic i_rst, // async reset
   input wire logic i_start, // offer
   input wire instr_t i_instr, // instruction bytes
   input wire logic o_ready, // idle
   input wire logic o_busy, // executing
   input wire logic o_done, // last cycle
   input wire logic o_bad_op, // refused opcode
   input wire logic [1:0] o_len, // length
   input wire rf_wr_t o_rf_wr, // register write
   input wire mem_wr_t o_mem_wr, // stack write
   input wire logic [15:0] o_sp, // stack pointer
   input wire logic o_flags_we // flag write
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   logic known;
   // opcodes handled here
   assign known = i_instr.opcode inside {8'h70, 8'h71, 8'h82};
   // seven busy cycles, done in the last
   sequence run_body;
      (o_busy && !o_done && !o_ready) [*6] ##1 (o_busy && o_done);
   endsequence
   sequence offer_ok;
      i_start && o_ready && known;
   endsequence
   a_run_length: assert property (
      offer_ok |=> run_body ##1 o_ready)
      else $error("instruction cycle count wrong");
   a_bad_refused: assert property (
      i_start && o_ready && !known |=> o_bad_op && o_ready)
      else $error("unknown opcode not refused");
   a_len_set: assert property (
      $rose(o_busy) |->
      o_len == ($past(i_instr.opcode) == 8'h82 ? 2'h3 : 2'h2))
      else $error("instruction length wrong");
   a_sp_step: assert property (
      o_mem_wr.en |-> o_sp == 16'($past(o_sp) - 16'h0001))
      else $error("pointer not decremented once");
   a_store_top: assert property (
      o_mem_wr.en |-> o_mem_wr.addr == o_sp)
      else $error("store not at new pointer");
   a_user_chain: assert property (
      o_rf_wr.en && !$past(o_rf_wr.en) |=>
      o_rf_wr.en && o_rf_wr.addr == $past(o_rf_wr.data))
      else $error("user store not at new pointer");
   a_user_no_mem: assert property (
      o_busy && o_len == 2'h3 |-> !o_mem_wr.en)
      else $error("user push wrote stack memory");
   a_flags_kept: assert property (
      !o_flags_we)
      else $error("flags written");
endmodule
bind stack_push_exec stack_push_checker chk (.i_ref_clk, .i_rst,
   .i_start, .i_instr, .o_ready, .o_busy, .o_done, .o_bad_op, .o_len,
   .o_rf_wr, .o_mem_wr, .o_sp, .o_flags_we);

// File: reg_file_model.sv
// register file model on the far side of the execution block
module reg_file_model
   import stack_push_pkg::*;
(
   input wire logic i_ref_clk, // core clock
   input wire rf_rd_t i_rd, // read request
   input wire rf_wr_t i_wr, // write request
   output logic [7:0] o_rd_data // data a cycle after request
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] regs [256];
   // start pattern: each byte holds its inverted address
   initial begin
      for (int a = 0; a < 256; a++)
         regs[a] = ~8'(a);
      o_rd_data = 8'h00;
   end
   // read answer lasts one cycle, then the line keeps toggling
   always @(posedge i_ref_clk) begin
      if (i_wr.en)
         regs[i_wr.addr] <= i_wr.data;
      if (i_rd.en)
         o_rd_data <= regs[i_rd.addr];
      else
         o_rd_data <= ~o_rd_data;
   end
endmodule

// File: tb.sv
// self-checking bench for the stack push execution block
module tb
   import stack_push_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {instr_t ins; logic [15:0] sp, addr, data;} row_t;
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_start = 1'b0;
   instr_t i_instr = '0;
   logic i_sp_hi_wr = 1'b0;
   logic i_sp_lo_wr = 1'b0;
   logic [7:0] i_sp_wr_data = 8'h00;
   logic o_ready, o_busy, o_done, o_bad_op, o_flags_we;
   logic [1:0] o_len;
   rf_rd_t o_rf_rd;
   rf_wr_t o_rf_wr;
   mem_wr_t o_mem_wr;
   logic [7:0] i_rf_rd_data;
   logic [15:0] o_sp, m_addr;
   logic [7:0] m_data;
   int n_fail = 0;
   int comparisons = 0;
   int m_cnt = 0;
   int n;
   // opcode, operands, pointer after, store address, stored byte
   row_t rows[5] = '{
      '{'{8'h70, 8'h40, 8'h00}, 16'hffff, 16'hffff, 16'h00bf},
      '{'{8'h71, 8'h40, 8'h00}, 16'hfffe, 16'hfffe, 16'h0040},
      '{'{8'h82, 8'h00, 8'h01}, 16'hfffe, 16'h00fe, 16'h00fe},
      '{'{8'h82, 8'h00, 8'h03}, 16'hfffe, 16'h00fd, 16'h00fc},
      '{'{8'h70, 8'hfd, 8'h00}, 16'hfffd, 16'hfffd, 16'h00fc}};
   stack_push_exec uut (.i_ref_clk, .i_rst, .i_start, .i_instr,
      .o_ready, .o_busy, .o_done, .o_bad_op, .o_len, .o_rf_rd,
      .i_rf_rd_data, .o_rf_wr, .o_mem_wr, .i_sp_hi_wr, .i_sp_lo_wr,
      .i_sp_wr_data, .o_sp, .o_flags_we);
   reg_file_model pm (.i_ref_clk, .i_rd(o_rf_rd), .i_wr(o_rf_wr),
      .o_rd_data(i_rf_rd_data));
   initial forever #20 i_ref_clk = ~i_ref_clk;
   // record stack memory writes
   always @(posedge i_ref_clk) begin
      if (o_mem_wr.en === 1'b1) begin
         m_cnt <= m_cnt + 1;
         m_addr <= o_mem_wr.addr;
         m_data <= o_mem_wr.data;
      end
   end
   task automatic tally_and_finish;
      if (n_fail == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   // offer held through busy (ignored), count cycles to done
   task automatic run(input instr_t ins);
      i_start = 1'b1;
      i_instr = ins;
      n = 0;
      while (o_done !== 1'b1 && n < 20) begin
         @(negedge i_ref_clk);
         n++;
      end
      if (n >= 20) begin
         n_fail++;
         tally_and_finish;
      end
      i_start = 1'b0;
      @(negedge i_ref_clk);
   endtask
   initial begin
      repeat (16) @(negedge i_ref_clk);
      i_rst = 1'b0;
      foreach (rows[k]) begin
         run(rows[k].ins);
         check(16'(n), 16'h0007);
         check(o_sp, rows[k].sp);
         if (rows[k].ins.opcode == 8'h82) begin
            check({8'h00, pm.regs[rows[k].ins.byte1]}, rows[k].addr);
            check({8'h00, pm.regs[rows[k].addr[7:0]]}, rows[k].data);
         end else begin
            check(m_addr, rows[k].addr);
            check({8'h00, m_data}, rows[k].data);
         end
      end
      check(16'(m_cnt), 16'h0003);
      // pointer loaded byte-wise, push borrows across bytes
      i_sp_hi_wr = 1'b1;
      i_sp_wr_data = 8'h01;
      @(negedge i_ref_clk);
      i_sp_hi_wr = 1'b0;
      i_sp_lo_wr = 1'b1;
      i_sp_wr_data = 8'h00;
      @(negedge i_ref_clk);
      i_sp_lo_wr = 1'b0;
      run('{8'h70, 8'h40, 8'h00});
      check(m_addr, 16'h00ff);
      check(o_sp, 16'h00ff);
      check({8'h00, m_data}, 16'h00bf);
      // unknown opcode refused, nothing stored
      i_start = 1'b1;
      i_instr = '{8'h83, 8'h40, 8'h00};
      @(negedge i_ref_clk);
      i_start = 1'b0;
      check({15'h0, o_bad_op}, 16'h0001);
      check({15'h0, o_busy}, 16'h0000);
      repeat (8) @(negedge i_ref_clk);
      check(16'(m_cnt), 16'h0004);
      // reset in mid-instruction drops it, pointer back to reset value
      i_start = 1'b1;
      i_instr = '{8'h71, 8'h40, 8'h00};
      @(negedge i_ref_clk);
      i_start = 1'b0;
      repeat (2) @(negedge i_ref_clk);
      check({15'h0, o_busy}, 16'h0001);
      i_rst = 1'b1;
      @(negedge i_ref_clk);
      check({15'h0, o_busy}, 16'h0000);
      check({15'h0, o_done}, 16'h0000);
      check(o_sp, 16'h0000);
      i_rst = 1'b0;
      run('{8'h70, 8'h40, 8'h00});
      check(16'(m_cnt), 16'h0005);
      check(m_addr, 16'hffff);
      check(o_sp, 16'hffff);
      tally_and_finish;
   end
endmodule
